/* File: design/ground_fault_trip_logic.v */
// Ground-fault, resistor-fault and trip relay decision logic with an Avalon-MM register slave.
//
// The address map and the Avalon-MM slave port were decided locally.
`include "gft_regs.vh"
`timescale 1ns/1ps
// How it works
// - Voltage and current thresholds are percent of nominal, 10 to 90, default 60.
// - High-resistance variant keeps lower 10-90 percent and upper 110-200 percent thresholds.
// - Low-resistance variant keeps only an upper threshold in ohms, 200 to 500.
// - Ground-fault relay operates after a fixed 40 ms of over-threshold current or voltage.
// - Resistor-fault relay operates after 100 ms plus the filter duration on resistance out of band.
// - With ground-fault tripping disabled, ground faults never switch the trip relay.
// - Resistor faults bypass the ground-fault delay and use the resistor-fault trip delay.
// - An active resistance filter lengthens resistance trip time by the filter duration.
// - Relays default fail-safe; a device test inverts every relay.
// - Calibration only in automatic method; failure raises error code 6.10.
// - Trip quantity is RMS, fundamental, or a harmonic band H0 to H32.
// - Passive method derives resistance from voltage and current; active uses injected pulse.
// - Display units: resistance ohms or percent (high variant only), current amps or percent.
module ground_fault_trip_logic #(
  parameter MS_W    = 28,
  parameter MS_DIV  = `MS_CYCLES,
  parameter CAL_MS  = `CAL_TIMEOUT_MS
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [3:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWritedata,
  output reg  [31:0] avsReaddata,
  output reg         avsWaitrequest,
  input  wire        sampleValid,
  input  wire [15:0] voltRms,
  input  wire [15:0] voltFund,
  input  wire [15:0] voltHarm,
  input  wire [15:0] currRms,
  input  wire [15:0] currFund,
  input  wire [15:0] currHarm,
  input  wire [15:0] resPassive,
  input  wire [15:0] resActive,
  input  wire        calDone,
  input  wire        calFail,
  output reg         groundFaultRelay_r,
  output reg         resistorFaultRelay_r,
  output reg         tripRelay_r,
  output reg         pulseInject_r,
  output reg         calRun_r
);
  // Ohm-valued resistance reading; v and i are percent of nominal.
  reg  [11:0] ctrl_r;
  reg  [8:0]  vThr_r;
  reg  [8:0]  iThr_r;
  reg  [8:0]  rLow_r;
  reg  [8:0]  rUpp_r;
  reg  [8:0]  rNom_r;
  reg  [MS_W-1:0] gfDly_r;
  reg  [MS_W-1:0] rfDly_r;
  reg  [15:0] filtMs_r;
  reg  [11:0] harm_r;
  reg  [15:0] errCode_r;
  reg  [MS_W-1:0] msDiv_r;
  reg         msTick_r;
  reg  [15:0] vSel_r;
  reg  [15:0] iSel_r;
  reg  [15:0] rSel_r;
  reg         gfCond_r;
  reg         rfCond_r;
  reg  [MS_W-1:0] gfCnt_r;
  reg  [MS_W-1:0] rfCnt_r;
  reg  [MS_W-1:0] tgCnt_r;
  reg  [MS_W-1:0] trCnt_r;
  reg  [MS_W-1:0] calCnt_r;
  reg         gfAct_r;
  reg         rfAct_r;
  reg         trAct_r;
  reg         pending_r;
  wire        hrv      = ctrl_r[`CTRL_HRV];
  wire        failSafe = ctrl_r[`CTRL_FAILSAFE];
  wire        testMode = ctrl_r[`CTRL_TEST];
  wire        devFail  = ctrl_r[`CTRL_DEVFAIL];
  wire [1:0]  qSel     = ctrl_r[`CTRL_QSEL_LSB+1:`CTRL_QSEL_LSB];
  wire [15:0] storeRd;
  wire [15:0] resNow   = ctrl_r[`CTRL_ACTIVE] ? resActive : resPassive;
  localparam [31:0] GF_DLY_RST = `GF_TRIP_MIN_MS;
  wire [31:0] gfDlyClamp = (avsWritedata < `GF_TRIP_MIN_MS) ? `GF_TRIP_MIN_MS :
                           ((avsWritedata > `TRIP_MAX_MS) ? `TRIP_MAX_MS : avsWritedata);
  wire [31:0] rfDlyClamp = (avsWritedata > `TRIP_MAX_MS) ? `TRIP_MAX_MS : avsWritedata;

  // Clamp a written threshold into its legal range.
  function [8:0] clampThr;
    input [31:0] v;
    input [8:0]  lo;
    input [8:0]  hi;
    begin
      if (v < {23'h000000, lo})
        clampThr = lo;
      else if (v > {23'h000000, hi})
        clampThr = hi;
      else
        clampThr = v[8:0];
    end
  endfunction
  // Choose among the three trip quantities; the measured-value readback takes the same choice.
  function [15:0] pickQty;
    input [1:0]  s;
    input [15:0] rms;
    input [15:0] fund;
    input [15:0] harm;
    begin
      case (s)
        `QSEL_FUND: pickQty = fund;
        `QSEL_HARM: pickQty = harm;
        default:    pickQty = rms;
      endcase
    end
  endfunction
  // Percent of nominal resistance as ohms: r * pct / 100; the quotient fits in 16 bits.
  function [15:0] pctOhm;
    input [8:0] nom;
    input [8:0] pct;
    reg   [17:0] p;
    begin
      p = (nom * pct) / 18'h00064;
      pctOhm = p[15:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      msDiv_r  <= {MS_W{1'b0}};
      msTick_r <= 1'b0;
    end
    else if (msDiv_r == MS_DIV - 1)
    begin
      msDiv_r  <= {MS_W{1'b0}};
      msTick_r <= 1'b1;
    end
    else
    begin
      msDiv_r  <= msDiv_r + 1'b1;
      msTick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and the Avalon-MM slave: one wait cycle, then the answer.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r   <= `CTRL_RST;
      vThr_r   <= {1'b0, `VTHR_RST};
      iThr_r   <= {1'b0, `ITHR_RST};
      rLow_r   <= `RLOW_RST;
      rUpp_r   <= `RUPP_LRV_RST;
      rNom_r   <= `RNOM_RST;
      gfDly_r  <= GF_DLY_RST[MS_W-1:0];
      rfDly_r  <= {MS_W{1'b0}};
      filtMs_r <= 16'h0000;
      harm_r   <= `HARM_RST;
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h00000000;
    end
    else
    begin
      ctrl_r[`CTRL_CAL_START] <= 1'b0;
      avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
      // A write lands at the edge at which the master sees waitrequest low.
      if (avsWrite && !avsWaitrequest)
      begin
        case (avsAddress)
          `REG_CTRL:
          begin
            ctrl_r <= avsWritedata[11:0];
            // Calibration start only in automatic method.
            ctrl_r[`CTRL_CAL_START] <= avsWritedata[`CTRL_CAL_START] & avsWritedata[`CTRL_AUTO];
            // Percent resistance display only in the high-resistance variant.
            ctrl_r[`CTRL_RPCT_DISP] <= avsWritedata[`CTRL_RPCT_DISP] & avsWritedata[`CTRL_HRV];
            if (avsWritedata[`CTRL_HRV] != hrv)
              rUpp_r <= avsWritedata[`CTRL_HRV] ? `RUPP_HRV_RST : `RUPP_LRV_RST;
          end
          `REG_VTHR: vThr_r <= clampThr(avsWritedata, `PCT_MIN, `PCT_MAX);
          `REG_ITHR: iThr_r <= clampThr(avsWritedata, `PCT_MIN, `PCT_MAX);
          `REG_RLOW: rLow_r <= clampThr(avsWritedata, `PCT_MIN, `PCT_MAX);
          `REG_RUPP: rUpp_r <= hrv ? clampThr(avsWritedata, `PCT_HI_MIN, `PCT_HI_MAX)
                                   : clampThr(avsWritedata, `OHM_MIN, `OHM_MAX);
          `REG_GFDLY: gfDly_r <= gfDlyClamp[MS_W-1:0];
          `REG_RFDLY: rfDly_r <= rfDlyClamp[MS_W-1:0];
          `REG_FILT: filtMs_r <= avsWritedata[15:0];
          `REG_HARM:
          begin
            // Band limits each kept within H0..H32, independently of each other.
            harm_r[5:0]  <= (avsWritedata[5:0] > `HARM_TOP) ? `HARM_TOP : avsWritedata[5:0];
            harm_r[11:6] <= (avsWritedata[11:6] > `HARM_TOP) ? `HARM_TOP : avsWritedata[11:6];
          end
          `REG_MEAS_V: rNom_r <= avsWritedata[8:0];
          default: ;
        endcase
      end
      if (avsRead && avsWaitrequest)
      begin
        case (avsAddress)
          `REG_CTRL:  avsReaddata <= {20'h00000, ctrl_r};
          `REG_VTHR:  avsReaddata <= {23'h000000, vThr_r};
          `REG_ITHR:  avsReaddata <= {23'h000000, iThr_r};
          `REG_RLOW:  avsReaddata <= {23'h000000, rLow_r};
          `REG_RUPP:  avsReaddata <= {23'h000000, rUpp_r};
          `REG_GFDLY: avsReaddata <= {{(32-MS_W){1'b0}}, gfDly_r};
          `REG_RFDLY: avsReaddata <= {{(32-MS_W){1'b0}}, rfDly_r};
          `REG_FILT:  avsReaddata <= {16'h0000, filtMs_r};
          `REG_STAT:  avsReaddata <= {errCode_r, 9'h000, calRun_r, pending_r, rfCond_r, gfCond_r,
                                      trAct_r, rfAct_r, gfAct_r};
          `REG_HARM:  avsReaddata <= {20'h00000, harm_r};
          default:    avsReaddata <= {16'h0000, storeRd};
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latest selected voltage, current and resistance, one slot written per cycle in turn.
  meas_store #(.AW (2), .DW (16)) uStore (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wrEn    (1'b1),
    .wrAddr  (msDiv_r[1:0]),
    .wrData  ((msDiv_r[1:0] == 2'h1) ? vSel_r : ((msDiv_r[1:0] == 2'h2) ? iSel_r : rSel_r)),
    .rdAddr  (avsAddress[1:0]),
    .rdData  (storeRd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sample the selected quantity and compare on every new sample.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      vSel_r   <= 16'h0000;
      iSel_r   <= 16'h0000;
      rSel_r   <= 16'h0000;
      gfCond_r <= 1'b0;
      rfCond_r <= 1'b0;
    end
    else if (sampleValid)
    begin
      vSel_r <= pickQty(qSel, voltRms, voltFund, voltHarm);
      iSel_r <= pickQty(qSel, currRms, currFund, currHarm);
      rSel_r <= resNow;
      gfCond_r <= (pickQty(qSel, voltRms, voltFund, voltHarm) > {7'h00, vThr_r}) ||
                  (pickQty(qSel, currRms, currFund, currHarm) > {7'h00, iThr_r});
      rfCond_r <= (hrv && resNow < pctOhm(rNom_r, rLow_r)) ||
                  (resNow > (hrv ? pctOhm(rNom_r, rUpp_r) : {7'h00, rUpp_r}));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Delay timers in ms; each restarts when its condition drops.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      gfCnt_r <= {MS_W{1'b0}};
      rfCnt_r <= {MS_W{1'b0}};
      tgCnt_r <= {MS_W{1'b0}};
      trCnt_r <= {MS_W{1'b0}};
      gfAct_r <= 1'b0;
      rfAct_r <= 1'b0;
      trAct_r <= 1'b0;
      pending_r <= 1'b0;
    end
    else
    begin
      if (!gfCond_r)
      begin
        gfCnt_r <= {MS_W{1'b0}};
        gfAct_r <= 1'b0;
      end
      else if (msTick_r && !gfAct_r)
      begin
        gfCnt_r <= gfCnt_r + 1'b1;
        gfAct_r <= (gfCnt_r + 1'b1 >= `GF_DELAY_MS);
      end
      if (!rfCond_r)
      begin
        rfCnt_r <= {MS_W{1'b0}};
        rfAct_r <= 1'b0;
      end
      else if (msTick_r && !rfAct_r)
      begin
        rfCnt_r <= rfCnt_r + 1'b1;
        rfAct_r <= (rfCnt_r + 1'b1 >= `RF_DELAY_MS + filtMs_r);
      end
      // Ground-fault trip timer runs only while ground-fault tripping is enabled.
      if (!gfCond_r || !ctrl_r[`CTRL_GFTRIP_EN])
        tgCnt_r <= {MS_W{1'b0}};
      else if (msTick_r && tgCnt_r < gfDly_r)
        tgCnt_r <= tgCnt_r + 1'b1;
      // Resistor-fault trip timer ignores the ground-fault delay.
      if (!rfCond_r)
        trCnt_r <= {MS_W{1'b0}};
      else if (msTick_r && trCnt_r < rfDly_r + filtMs_r)
        trCnt_r <= trCnt_r + 1'b1;
      pending_r <= gfCond_r | rfCond_r;
      trAct_r <= devFail ||
                 (ctrl_r[`CTRL_GFTRIP_EN] && gfCond_r && tgCnt_r >= gfDly_r) ||
                 (rfCond_r && trCnt_r >= rfDly_r + filtMs_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer and error code.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      calRun_r     <= 1'b0;
      calCnt_r     <= {MS_W{1'b0}};
      errCode_r    <= 16'h0000;
    end
    else if (ctrl_r[`CTRL_CAL_START] && !calRun_r)
    begin
      calRun_r  <= 1'b1;
      calCnt_r  <= {MS_W{1'b0}};
      errCode_r <= 16'h0000;
    end
    else if (calRun_r)
    begin
      if (calDone && !calFail)
        calRun_r <= 1'b0;
      else if (calFail || calCnt_r >= CAL_MS || !ctrl_r[`CTRL_AUTO])
      begin
        calRun_r  <= 1'b0;
        errCode_r <= `ERR_CAL;
      end
      else if (msTick_r)
        calCnt_r <= calCnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Relay drive: fail-safe energises when idle; test inverts every relay.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      groundFaultRelay_r   <= 1'b0;
      resistorFaultRelay_r <= 1'b0;
      tripRelay_r          <= 1'b0;
      pulseInject_r        <= 1'b0;
    end
    else
    begin
      groundFaultRelay_r   <= (gfAct_r ^ failSafe) ^ testMode;
      resistorFaultRelay_r <= (rfAct_r ^ failSafe) ^ testMode;
      tripRelay_r          <= (trAct_r ^ failSafe) ^ testMode;
      pulseInject_r        <= ctrl_r[`CTRL_ACTIVE] & msTick_r;
    end
  end
endmodule

/* File: design/gft_regs.vh */
// Register offsets, field positions, reset values and timing counts of the ground-fault trip logic.
`ifndef GFT_REGS_VH
`define GFT_REGS_VH
// Word offsets (byte address = 4 * index).
`define REG_CTRL        4'h0
`define REG_VTHR        4'h1
`define REG_ITHR        4'h2
`define REG_RLOW        4'h3
`define REG_RUPP        4'h4
`define REG_GFDLY       4'h5
`define REG_RFDLY       4'h6
`define REG_FILT        4'h7
`define REG_STAT        4'h8
`define REG_MEAS_V      4'h9
`define REG_MEAS_I      4'ha
`define REG_MEAS_R      4'hb
`define REG_HARM        4'hc
// Control field positions.
`define CTRL_HRV        0
`define CTRL_GFTRIP_EN  1
`define CTRL_ACTIVE     2
`define CTRL_AUTO       3
`define CTRL_FAILSAFE   4
`define CTRL_TEST       5
`define CTRL_CAL_START  6
`define CTRL_DEVFAIL    7
`define CTRL_QSEL_LSB   8
`define CTRL_RPCT_DISP  10
`define CTRL_IPCT_DISP  11
// Trip quantity selections.
`define QSEL_RMS        2'h0
`define QSEL_FUND       2'h1
`define QSEL_HARM       2'h2
// Reset values (thresholds in percent or ohms, control word, harmonic band).
`define VTHR_RST        8'h3c
`define ITHR_RST        8'h3c
`define RLOW_RST        9'h032
`define RUPP_HRV_RST    9'h0c8
`define RUPP_LRV_RST    9'h0fa
`define CTRL_RST        12'h012
`define HARM_RST        12'h200
`define RNOM_RST        9'h096
// Threshold limits.
`define PCT_MIN         9'h00a
`define PCT_MAX         9'h05a
`define PCT_HI_MIN      9'h06e
`define PCT_HI_MAX      9'h0c8
`define OHM_MIN         9'h0c8
`define OHM_MAX         9'h1f4
`define HARM_TOP        6'h20
// Error code 6.10 as two BCD bytes.
`define ERR_CAL         16'h0610
// Times: the ms tick base and fixed delays.
`define CLK_HZ          100000000
`define TICK_MS         1
`define GF_DELAY_MS     40
`define RF_DELAY_MS     100
`define GF_TRIP_MIN_MS  100
`define TRIP_MAX_MS     172800000
`define CAL_TIMEOUT_MS  1000
`define MS_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`endif

/* File: design/meas_store.v */
// Small register-read memory holding the latest measured quantities.
`timescale 1ns/1ps
module meas_store #(
  parameter AW = 2,
  parameter DW = 16
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write port stores new samples; read data leave through a register.
  always @(posedge clk_sys)
  begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end

  // Registered read keeps the bus path short.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdData <= 16'h0000;
    else
      rdData <= mem[rdAddr];
  end
endmodule

/* File: verif/gft_assertions.sv */
// Concurrent checks on the ports of the ground-fault trip logic.
`timescale 1ns/1ps
module gft_assertions #(
  parameter MS_DIV = 100000
) (
  input wire        clk_sys,
  input wire        rst,
  input wire [3:0]  avsAddress,
  input wire        avsRead,
  input wire        avsWrite,
  input wire [31:0] avsWritedata,
  input wire [31:0] avsReaddata,
  input wire        avsWaitrequest,
  input wire        groundFaultRelay_r,
  input wire        resistorFaultRelay_r,
  input wire        tripRelay_r,
  input wire        pulseInject_r,
  input wire        calRun_r
);
  localparam int GF_MIN = 39 * MS_DIV;
  localparam int RF_MIN = 99 * MS_DIV;
  wire       ctlWr;
  reg [31:0] quiet_r;
  reg [31:0] calAge_r;
  reg [31:0] gfHigh_r;
  reg [31:0] rfHigh_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A control write takes effect at the edge that sees waitrequest low.
  assign ctlWr = avsWrite && !avsWaitrequest && avsAddress == 4'h0;
  // Saturating ages of the last control write and the last calibration request; counts of the ground and resistor relays' high spells.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      quiet_r  <= 32'h0;
      calAge_r <= 32'hffff;
      gfHigh_r <= 32'h0;
      rfHigh_r <= 32'h0;
    end
    else
    begin
      quiet_r  <= ctlWr ? 32'h0 : quiet_r + {31'h0, ~&quiet_r};
      calAge_r <= (ctlWr && avsWritedata[6] && avsWritedata[3]) ? 32'h0 : calAge_r + {31'h0, ~&calAge_r};
      gfHigh_r <= groundFaultRelay_r ? gfHigh_r + 32'h1 : 32'h0;
      rfHigh_r <= resistorFaultRelay_r ? rfHigh_r + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////
  sequence s_answer;
    !avsWaitrequest ##1 avsWaitrequest;
  endsequence
  property p_answer;
    (avsRead || avsWrite) && avsWaitrequest |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer is not one wait cycle");
  property p_rdHold;
    !(avsRead && avsWaitrequest) |=> $stable(avsReaddata);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data changed without a read");
  property p_pulse;
    pulseInject_r |=> !pulseInject_r [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("test pulses closer than one tick");
  property p_gf;
    $fell(groundFaultRelay_r) && quiet_r > 32'h8 |-> gfHigh_r >= GF_MIN;
  endproperty
  a_gf: assert property (p_gf) else $error("ground relay operated early");
  property p_rf;
    $fell(resistorFaultRelay_r) && quiet_r > 32'h8 |-> rfHigh_r >= RF_MIN;
  endproperty
  a_rf: assert property (p_rf) else $error("resistor relay operated early");
  property p_cal;
    $rose(calRun_r) |-> calAge_r <= 32'h3;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration started without request in auto");
  property p_test;
    ctlWr && avsWritedata[5] && avsWritedata[4] |-> ##[1:3] !(groundFaultRelay_r || resistorFaultRelay_r || tripRelay_r);
  endproperty
  a_test: assert property (p_test) else $error("device test did not flip the relays");
  property p_devFail;
    ctlWr && avsWritedata[7] && avsWritedata[4] |-> ##[1:3] !tripRelay_r;
  endproperty
  a_devFail: assert property (p_devFail) else $error("device failure did not trip at once");
endmodule
bind ground_fault_trip_logic gft_assertions #(.MS_DIV(MS_DIV)) i_chk (.*);

/* File: verif/switchgear_model.sv */
// Behavioural switchgear and calibration engine on the relay side of the trip logic.
`timescale 1ns/1ps
module switchgear_model (
  input  wire clk_sys,
  input  wire rst,
  input  wire tripRelay_r,
  input  wire calRun_r,
  input  wire failMode,
  input  wire slowMode,
  output reg  calDone,
  output reg  calFail,
  output reg  breakerOpen_r
);
  reg [5:0] calCnt_r;
  // Breaker opens once the fail-safe trip coil drops; calibration answers one pulse, fast or slow.
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      calCnt_r <= 6'h0;
      calDone <= 1'b0;
      calFail <= 1'b0;
      breakerOpen_r <= 1'b0;
    end
    else
    begin
      calCnt_r <= calRun_r ? calCnt_r + {5'h0, ~&calCnt_r} : 6'h0;
      calDone <= calCnt_r == (slowMode ? 6'h28 : 6'h3) && !failMode;
      calFail <= calCnt_r == (slowMode ? 6'h28 : 6'h3) && failMode;
      breakerOpen_r <= breakerOpen_r | !tripRelay_r;
    end
  end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the ground-fault trip logic with a switchgear model.
`timescale 1ns/1ps
module tb;
  reg         clk_sys = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  avsAddress = 4'h0;
  reg         avsRead = 1'b0;
  reg         avsWrite = 1'b0;
  reg  [31:0] avsWritedata = 32'h0;
  wire [31:0] avsReaddata;
  wire        avsWaitrequest;
  reg         sampleValid = 1'b0;
  reg  [15:0] vRms = 16'h0, vFund = 16'h0, vHarm = 16'h0, iRms = 16'h0, iFund = 16'h0, iHarm = 16'h0;
  reg  [15:0] rPas = 16'h96, rAct = 16'h96;
  reg         failMode = 1'b0, slowMode = 1'b0;
  wire        calDone, calFail, gfRel, rfRel, trip, pulse, calRun, brkOpen;
  reg  [31:0] q, seed = 32'h33fa01dd;
  integer     err_total = 0, num_checks = 0, i, k, n;
  // Clock at 100 MHz and one new measurement every other cycle.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) sampleValid <= ~sampleValid;
  ground_fault_trip_logic #(.MS_DIV(10)) i_dut (.clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .sampleValid(sampleValid), .voltRms(vRms), .voltFund(vFund),
    .voltHarm(vHarm), .currRms(iRms), .currFund(iFund), .currHarm(iHarm), .resPassive(rPas),
    .resActive(rAct), .calDone(calDone), .calFail(calFail), .groundFaultRelay_r(gfRel),
    .resistorFaultRelay_r(rfRel), .tripRelay_r(trip), .pulseInject_r(pulse), .calRun_r(calRun));
  switchgear_model i_sw (.clk_sys(clk_sys), .rst(rst), .tripRelay_r(trip), .calRun_r(calRun),
    .failMode(failMode), .slowMode(slowMode), .calDone(calDone), .calFail(calFail), .breakerOpen_r(brkOpen));
  ////////////////////////////////////////
  // Expected values and the random source.
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [31:0] pct(input [31:0] v);
    pct = v < 10 ? 10 : (v > 90 ? 90 : v);
  endfunction
  function [31:0] rstVal(input [3:0] a);
    rstVal = a == 0 ? 32'h12 : (a == 3 ? 32'h32 : (a == 4 ? 32'hfa : 32'h3c));
  endfunction
  // Verdict, comparison, waits, reset and bus cycles.
  task complete_run;
    begin
      if (err_total == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge clk_sys);
  endtask
  task doRst;
    begin
      rst <= 1'b1;
      cyc(4);
      rst <= 1'b0;
      cyc(1);
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer t;
    begin
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= w;
      avsRead <= !w;
      t = 0;
      @(posedge clk_sys);
      while (avsWaitrequest !== 1'b0)
      begin
        t = t + 1;
        if (t > 50)
        begin
          chk(t, 0);
          complete_run;
        end
        @(posedge clk_sys);
      end
      q = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task setQ(input integer s, input [15:0] on, input [15:0] off);
    begin
      vRms <= s == 0 ? on : off;
      iRms <= s == 0 ? on : off;
      vFund <= s == 1 ? on : off;
      iFund <= s == 1 ? on : off;
      vHarm <= s == 2 ? on : off;
      iHarm <= s == 2 ? on : off;
    end
  endtask
  ////////////////////////////////////////
  // Main sequence of scenarios.
  initial
  begin
    doRst;
    for (i = 0; i < 5; i = i + 1)
    begin
      bus(0, i, 0);
      chk(q, rstVal(i));
    end
    for (i = 0; i < 7; i = i + 1)
    begin
      seed = lfsr(seed);
      k = i == 0 ? 9 : (i == 1 ? 91 : seed[7:0]);
      bus(1, 1 + i % 3, k);
      bus(0, 1 + i % 3, 0);
      chk(q, pct(k));
    end
    bus(1, 15, 0);
    bus(0, 0, 0);
    chk(q, 32'h12);
    for (i = 0; i < 3; i = i + 1)
    begin
      doRst;
      bus(1, 0, 32'h12 | (i << 8));
      setQ(i, 0, 95);
      cyc(450);
      chk(gfRel, 1);
      setQ(i, 70, 0);
      cyc(350);
      chk(gfRel, 1);
      cyc(100);
      chk(gfRel, 0);
      setQ(i, 0, 0);
      cyc(30);
      chk(gfRel, 1);
    end
    setQ(2, 70, 0);
    cyc(300);
    setQ(2, 0, 0);
    cyc(20);
    setQ(2, 70, 0);
    cyc(300);
    chk(gfRel, 1);
    setQ(2, 0, 0);
    for (i = 0; i < 2; i = i + 1)
    begin
      doRst;
      bus(1, 0, i ? 32'h10 : 32'h12);
      bus(1, 5, 100);
      vRms <= 16'h46;
      cyc(950);
      chk(trip, 1);
      cyc(600);
      chk(trip, i);
      vRms <= 16'h0;
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      doRst;
      bus(1, 5, 2000);
      bus(1, 6, 0);
      bus(1, 7, i * 20);
      rPas <= 16'h12c;
      cyc(950 + i * 200);
      chk(rfRel, 1);
      cyc(150);
      chk({rfRel, trip}, 0);
      rPas <= 16'h96;
    end
    // High-resistance variant: percent display, upper clamp and the lower threshold.
    doRst;
    bus(1, 0, 32'h412);
    bus(0, 0, 0);
    chk(q, 32'h12);
    bus(1, 0, 32'h413);
    bus(0, 0, 0);
    chk(q, 32'h413);
    bus(0, 4, 0);
    chk(q, 32'hc8);
    bus(1, 4, 105);
    bus(0, 4, 0);
    chk(q, 32'h6e);
    rPas <= 16'h3c;
    cyc(900);
    chk(rfRel, 1);
    cyc(200);
    chk(rfRel, 0);
    rPas <= 16'h96;
    doRst;
    cyc(1);
    chk({gfRel, rfRel, trip}, 7);
    bus(1, 0, 32'h32);
    cyc(2);
    chk({gfRel, rfRel, trip}, 0);
    bus(1, 0, 32'h16);
    n = 0;
    for (k = 0; k < 200; k = k + 1)
    begin
      @(posedge clk_sys);
      n = n + pulse;
    end
    chk(n, 20);
    bus(1, 0, 32'h52);
    cyc(3);
    chk(calRun, 0);
    bus(1, 0, 32'h12);
    bus(1, 0, 32'h5a);
    cyc(3);
    chk(calRun, 1);
    cyc(10);
    chk(calRun, 0);
    bus(1, 0, 32'h12);
    failMode <= 1'b1;
    slowMode <= 1'b1;
    bus(1, 0, 32'h5a);
    cyc(60);
    bus(0, 8, 0);
    chk(q[31:16], 16'h0610);
    doRst;
    bus(1, 0, 32'h92);
    cyc(3);
    chk({trip, brkOpen}, 1);
    complete_run;
  end
  // Cut a hung run short.
  initial
  begin
    #300000;
    chk(0, 1);
    complete_run;
  end
endmodule
